// >>> dv/amsi_modem_if_properties.sv
module amsi_modem_if_properties
    import amsi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic bus_init,
    input wire logic prog_reset,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire amsi_modem_out_type modem_out,
    input wire logic serial_tx,
    input wire logic sync_mode,
    input wire logic rx_irq,
    input wire logic tx_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Accesses that no initialize overrides.
    wire quiet = !bus_init && !prog_reset;
    wire any_rx_wr = reg_wr && reg_addr == amsi_rx_csr_addr;
    wire wr_rx_csr = any_rx_wr && quiet;
    wire wr_tx_csr = reg_wr && reg_addr == amsi_tx_csr_addr && quiet;
    wire wr_tx_buf = reg_wr && reg_addr == amsi_tx_buf_addr && quiet;
    wire rd_rx_buf = reg_rd && reg_addr == amsi_rx_buf_addr;
    // A control write that nothing disturbs in the following cycle.
    sequence s_csr_set;
        wr_rx_csr ##1 (quiet && !any_rx_wr);
    endsequence
    // A character loaded while the buffer was free and its irq enabled.
    sequence s_load_char;
        wr_tx_buf && tx_irq;
    endsequence
    // An initialize with no write right behind it.
    sequence s_init;
        bus_init ##1 !reg_wr;
    endsequence
    a_dtr_follows: assert property (s_csr_set |=>
        modem_out.dtr == $past(reg_wdata[amsi_pos_dtr], 2))
        else $error("terminal ready does not follow its bit");
    a_rts_follows: assert property (s_csr_set |=>
        modem_out.rts == $past(reg_wdata[amsi_pos_rts], 2))
        else $error("request to send does not follow its bit");
    a_revtx_follows: assert property (s_csr_set |=>
        modem_out.rev_tx == $past(reg_wdata[amsi_pos_rev_tx], 2))
        else $error("reverse channel does not follow its bit");
    a_init_modem: assert property (s_init |=> modem_out == '0)
        else $error("initialize left a modem control asserted");
    a_init_irqs: assert property (s_init |=> !rx_irq && !tx_irq)
        else $error("initialize left an interrupt request");
    a_prog_async: assert property (prog_reset ##1 !reg_wr |=>
        !sync_mode && !rx_irq && !tx_irq)
        else $error("programmed reset did not restore async idle");
    a_tx_mask: assert property (
        wr_tx_csr && !reg_wdata[amsi_pos_tx_ie] |-> ##2 !tx_irq)
        else $error("transmit irq survives a cleared enable");
    a_load_busy: assert property (s_load_char |-> ##2 !tx_irq)
        else $error("transmit ready stays set after a load");
    a_break_space: assert property (
        wr_tx_csr && reg_wdata[amsi_pos_break] |-> ##[1:3] !serial_tx)
        else $error("break did not drive space");
    a_error_or: assert property (rd_rx_buf |=>
        reg_rdata[amsi_pos_err_any] == |reg_rdata[14:12])
        else $error("combined error is not the or of the flags");
endmodule // amsi_modem_if_properties

bind amsi_modem_if amsi_modem_if_properties i_props (.*);

// >>> dv/amsi_modem_partner.sv
module amsi_modem_partner
    import amsi_pkg::*;
(
    input wire logic ref_clk,
    input wire amsi_modem_out_type modem_out,
    output logic serial_rx,
    output amsi_modem_in_type modem_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ring = 1'b0; // Ring line, moved by the bench.
    logic carrier = 1'b0; // Carrier line, moved by the bench.
    // The data set answers the terminal's control lines like a real one.
    assign modem_in = {ring, modem_out.rts, carrier, modem_out.rev_tx,
                       modem_out.dtr};
    // The line idles at mark, as its pull-up holds it.
    initial serial_rx = 1'b1;
    // Sends start, n bits low first, a stop of the given level, then idle.
    task automatic send(input logic [7:0] w, input int n, input logic stop);
        serial_rx <= 1'b0;
        repeat (amsi_bit_cycles) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            serial_rx <= w[i];
            repeat (amsi_bit_cycles) @(posedge ref_clk);
        end
        serial_rx <= stop;
        repeat (amsi_bit_cycles) @(posedge ref_clk);
        serial_rx <= 1'b1;
        repeat (amsi_bit_cycles) @(posedge ref_clk);
    endtask
endmodule // amsi_modem_partner

// >>> dv/testbench.sv
module testbench import amsi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic bus_init = 1'b0;
    logic prog_reset = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] line_param = 8'h0c;
    logic [15:0] reg_rdata;
    logic serial_rx, serial_tx, sync_mode, rx_irq, tx_irq;
    amsi_modem_in_type modem_in;
    amsi_modem_out_type modem_out;
    int num_errors = 0;
    int n_checks = 0;
    // One received frame: parameters, bits on the line, expected buffer.
    typedef struct {
        logic [7:0] lp;
        logic [7:0] w;
        int n;
        logic stop;
        logic [15:0] e;
    } amsi_row_type;
    amsi_row_type rows [4] = '{
        '{8'h0c, 8'ha5, 8, 1'b1, 16'h00a5},
        '{8'h18, 8'h41, 8, 1'b1, 16'h9041},
        '{8'h30, 8'h35, 6, 1'b1, 16'h0035},
        '{8'h04, 8'h2a, 6, 1'b0, 16'ha02a}};
    always #50 ref_clk = ~ref_clk;
    amsi_modem_if i_dut (.*);
    amsi_modem_partner i_modem (.*);
    // Counts one comparison and reports a mismatch.
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // One-cycle register write.
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read; the data are compared in the cycle that follows.
    task automatic rd_chk(input logic [1:0] a, input logic [15:0] e,
                          input logic [15:0] m);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask
    // Bounded wait: 0 receive irq, 1 transmit irq, 2 serial output.
    task automatic wait_sig(input int s, input logic v, input int lim);
        logic cur;
        for (int i = 0; i < lim; i++) begin
            @(posedge ref_clk);
            #1;
            cur = s == 0 ? rx_irq : (s == 1 ? tx_irq : serial_tx);
            if (cur === v) return;
        end
        num_errors++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        conclude();
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd_chk(amsi_tx_csr_addr, 16'h0080, 16'hffff);
        rd_chk(amsi_tx_buf_addr, 16'h0000, 16'hffff);
        wr(amsi_rx_csr_addr, 16'h0040);
        rd_chk(amsi_rx_csr_addr, 16'h0040, 16'h00ff);
        $display("reset and access test done");
        foreach (rows[i]) begin
            line_param <= rows[i].lp;
            i_modem.send(rows[i].w, rows[i].n, rows[i].stop);
            wait_sig(0, 1'b1, 2000);
            rd_chk(amsi_rx_buf_addr, rows[i].e, 16'hffff);
            wait_sig(0, 1'b0, 4);
        end
        $display("receive table done");
        line_param <= 8'h0c;
        i_modem.send(8'h11, 8, 1'b1);
        i_modem.send(8'h22, 8, 1'b1);
        rd_chk(amsi_rx_buf_addr, 16'hc000, 16'hff00);
        rd_chk(amsi_rx_buf_addr, 16'h0000, 16'hf000);
        $display("overrun test done");
        wr(amsi_rx_csr_addr, 16'h002e);
        wait_sig(0, 1'b1, 20);
        chk(16'(modem_out), 16'h0007);
        rd_chk(amsi_rx_csr_addr, 16'ha62e, 16'hffff);
        wait_sig(0, 1'b0, 4);
        i_modem.ring <= 1'b1;
        i_modem.carrier <= 1'b1;
        wait_sig(0, 1'b1, 20);
        rd_chk(amsi_rx_csr_addr, 16'hf62e, 16'hffff);
        i_modem.ring <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rd_chk(amsi_rx_csr_addr, 16'h362e, 16'hffff);
        bus_init <= 1'b1;
        @(posedge ref_clk);
        bus_init <= 1'b0;
        repeat (12) @(posedge ref_clk);
        chk(16'(modem_out), 16'h0000);
        rd_chk(amsi_rx_csr_addr, 16'h9000, 16'hffff);
        $display("modem line test done");
        wr(amsi_tx_csr_addr, 16'h0040);
        wait_sig(1, 1'b1, 4);
        wr(amsi_tx_buf_addr, 16'h005a);
        rd_chk(amsi_tx_csr_addr, 16'h0040, 16'hffff);
        wait_sig(2, 1'b0, 20);
        wait_sig(1, 1'b1, 12000);
        wr(amsi_tx_csr_addr, 16'h0001);
        repeat (1100) @(posedge ref_clk);
        chk(16'(serial_tx), 16'h0000);
        prog_reset <= 1'b1;
        @(posedge ref_clk);
        prog_reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({serial_tx, sync_mode}, 16'h0002);
        rd_chk(amsi_tx_csr_addr, 16'h0080, 16'hffff);
        $display("transmit and break test done");
        conclude();
    end
endmodule // testbench

// >>> rtl/amsi_modem_if.sv
// Contract
// - Bit 10 shows reverse channel, space=1.
// - Bit 9 mirrors ready; change flags.
// - Received character sets bit 7, interrupt.
// - Buffer access or init clears available.
// - Bit 5 enables line-change interrupt.
// - Bit 3 drives reverse channel space.
// - Bit 2 drives request to send.
// - Bit 1 drives data terminal ready.
// - Buffer bit 15 ORs error bits.
// - Error clears when cause goes away.
// - New character before clear sets overrun.
// - Missing stop bit sets framing flag.
// - Parity mismatch flagged, zero if off; 8-bit characters never take parity, so nothing is checked or flagged for them.
// - Character right-justified, init keeps data.
// - Parity bit placed above character.
// - Transmit free flag and its interrupt.
// - Break bit sends continuous space.
// - Programmed reset forces async, clears flags.
// - Modem line changes set line-change flag; ring sets it only when it comes on, not when it goes off.
// - Two-bit field selects 5 to 8 bits.
//
// Chosen here: the register addresses and the address-and-strobe port.
module amsi_modem_if
    import amsi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic bus_init,
    input wire logic prog_reset,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [7:0] line_param,
    input wire amsi_modem_in_type modem_in,
    input wire logic serial_rx,
    output logic serial_tx,
    output amsi_modem_out_type modem_out,
    output logic sync_mode,
    output logic rx_irq,
    output logic tx_irq
);

    // Three-stage synchronisers for all pin inputs; stage 0 feeds stage 1 only.
    logic [5:0] pin_s0;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    // Filtered pin levels, updated when stages 1 and 2 agree.
    logic [5:0] pin_q;
    // Bus-initialise or programmed reset, both clear the flags.
    logic init_any;
    // Control bits written by software.
    logic rx_irq_enable;
    logic line_change_irq_enable;
    logic reverse_channel_tx_bit;
    logic rts_bit;
    logic dtr_bit;
    logic tx_irq_enable;
    logic break_bit;
    // Status flags.
    logic line_change_flag;
    logic rx_char_available;
    logic tx_buffer_free;
    logic overrun_flag;
    logic framing_flag;
    logic parity_flag;
    // Received character word.
    logic [7:0] rx_data;
    // Receiver engine.
    amsi_state_type rx_state;
    logic [11:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    logic rx_done_pulse;
    logic rx_parity_bad;
    // Transmitter engine.
    amsi_state_type tx_state;
    logic [11:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [8:0] tx_shift;
    logic tx_pending;
    logic [7:0] tx_hold;
    // Decoded line parameters.
    logic [3:0] char_len;
    logic parity_on;
    logic [3:0] frame_bits;
    // Register-port decodes.
    logic rd_rx_csr;
    logic rd_rx_buf;
    logic wr_tx_buf;
    logic [4:0] line_now;
    logic [4:0] line_prev;

    // Decodes the character length field into a bit count.
    function automatic logic [3:0] len_of(input logic [1:0] code);
        len_of = 4'h5 + {2'h0, code};
    endfunction

    // Builds the parity of a character under the length mask.
    function automatic logic par_of(input logic [8:0] bits,
                                    input logic [3:0] n);
        logic p;
        p = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                p = p ^ bits[i];
            end
        end
        par_of = p;
    endfunction

    // Decodes the length parameter and parity enable.
    assign char_len = len_of(line_param[amsi_pos_len_hi:amsi_pos_len_lo]);
    assign parity_on = line_param[amsi_pos_par_on] & (char_len != 4'h8);
    assign frame_bits = char_len + {3'h0, parity_on};
    assign init_any = bus_init | prog_reset;
    assign rd_rx_csr = reg_rd & (reg_addr == amsi_rx_csr_addr);
    assign rd_rx_buf = (reg_rd | reg_wr) & (reg_addr == amsi_rx_buf_addr);
    assign wr_tx_buf = reg_wr & (reg_addr == amsi_tx_buf_addr);
    assign line_now = pin_q[4:0];

    // Synchronises the modem lines and serial data, three flip-flops deep.
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    pin_s0[g] <= 1'b1;
                    pin_s1[g] <= 1'b1;
                    pin_s2[g] <= 1'b1;
                    pin_q[g] <= 1'b1;
                end else begin
                    pin_s0[g] <= (g == 5) ? serial_rx : modem_in[g];
                    pin_s1[g] <= pin_s0[g];
                    pin_s2[g] <= pin_s1[g];
                    if (pin_s1[g] == pin_s2[g]) begin
                        pin_q[g] <= pin_s2[g];
                    end
                end
            end
        end
    endgenerate

    // Keeps the previous modem line levels for change detection.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_prev <= 5'h1f;
        end else begin
            line_prev <= line_now;
        end
    end

    // Synchronous mode is never set; reset and programmed reset force async.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_mode <= 1'b0;
        end else if (prog_reset) begin
            sync_mode <= 1'b0;
        end
    end

    // Software-written control bits, all cleared by initialise.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_irq_enable <= 1'b0;
            line_change_irq_enable <= 1'b0;
            reverse_channel_tx_bit <= 1'b0;
            rts_bit <= 1'b0;
            dtr_bit <= 1'b0;
            tx_irq_enable <= 1'b0;
            break_bit <= 1'b0;
        end else if (init_any) begin
            rx_irq_enable <= 1'b0;
            line_change_irq_enable <= 1'b0;
            reverse_channel_tx_bit <= 1'b0;
            rts_bit <= 1'b0;
            dtr_bit <= 1'b0;
            tx_irq_enable <= 1'b0;
            break_bit <= 1'b0;
        end else if (reg_wr && reg_addr == amsi_rx_csr_addr) begin
            rx_irq_enable <= reg_wdata[amsi_pos_rx_ie];
            line_change_irq_enable <= reg_wdata[amsi_pos_lc_ie];
            reverse_channel_tx_bit <= reg_wdata[amsi_pos_rev_tx];
            rts_bit <= reg_wdata[amsi_pos_rts];
            dtr_bit <= reg_wdata[amsi_pos_dtr];
        end else if (reg_wr && reg_addr == amsi_tx_csr_addr) begin
            tx_irq_enable <= reg_wdata[amsi_pos_tx_ie];
            break_bit <= reg_wdata[amsi_pos_break];
        end
    end

    // Line-change flag: a change wins over the clearing read.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_change_flag <= 1'b0;
        end else if (init_any) begin
            line_change_flag <= 1'b0;
        end else if ((line_now[3:0] != line_prev[3:0]) ||
                     (line_now[4] && !line_prev[4])) begin
            line_change_flag <= 1'b1;
        end else if (rd_rx_csr) begin
            line_change_flag <= 1'b0;
        end
    end

    // Receiver engine: start, data plus parity, stop, sampled mid-bit.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state <= amsi_idle;
            rx_cnt <= 12'h000;
            rx_bits <= 4'h0;
            rx_shift <= 9'h000;
        end else begin
            case (rx_state)
                amsi_idle: begin
                    rx_bits <= 4'h0;
                    rx_cnt <= amsi_half_cycles;
                    if (!pin_q[5]) begin
                        rx_state <= amsi_start;
                    end
                end
                amsi_start: begin
                    // Confirms the start bit at its middle.
                    if (rx_cnt == 12'h000) begin
                        rx_cnt <= amsi_bit_cycles;
                        rx_state <= pin_q[5] ? amsi_idle : amsi_data;
                    end else begin
                        rx_cnt <= rx_cnt - 12'h001;
                    end
                end
                amsi_data: begin
                    // Stores each bit LSB first at its own index, so the word is already right-aligned.
                    if (rx_cnt == 12'h000) begin
                        rx_cnt <= amsi_bit_cycles;
                        rx_shift[rx_bits] <= pin_q[5];
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_bits + 4'h1 == frame_bits) begin
                            rx_state <= amsi_stop;
                        end
                    end else begin
                        rx_cnt <= rx_cnt - 12'h001;
                    end
                end
                amsi_stop: begin
                    if (rx_cnt == 12'h000) begin
                        rx_state <= amsi_idle;
                    end else begin
                        rx_cnt <= rx_cnt - 12'h001;
                    end
                end
                default: begin
                    rx_state <= amsi_idle;
                end
            endcase
        end
    end

    // A character is complete at the middle of its stop bit.
    assign rx_done_pulse = (rx_state == amsi_stop) && (rx_cnt == 12'h000);
    assign rx_parity_bad = parity_on &&
        (par_of(rx_shift, frame_bits) != !line_param[amsi_pos_par_type]);

    // Receive buffer: data kept through init, parity bit above character.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_data <= 8'h00;
        end else if (rx_done_pulse) begin
            for (int i = 0; i < 8; i++) begin
                rx_data[i] <= (4'(i) < frame_bits) ? rx_shift[i] : 1'b0;
            end
        end
    end

    // Receive status flags; a new character wins over a clearing access.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_char_available <= 1'b0;
            overrun_flag <= 1'b0;
            framing_flag <= 1'b0;
            parity_flag <= 1'b0;
        end else if (init_any) begin
            rx_char_available <= 1'b0;
            overrun_flag <= 1'b0;
            framing_flag <= 1'b0;
            parity_flag <= 1'b0;
        end else if (rx_done_pulse) begin
            rx_char_available <= 1'b1;
            overrun_flag <= rx_char_available && !rd_rx_buf;
            framing_flag <= !pin_q[5];
            parity_flag <= rx_parity_bad;
        end else if (rd_rx_buf) begin
            rx_char_available <= 1'b0;
            overrun_flag <= 1'b0;
            framing_flag <= 1'b0;
            parity_flag <= 1'b0;
        end else if (!parity_on) begin
            parity_flag <= 1'b0;
        end
    end

    // Transmit holding register and ready flag.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_buffer_free <= 1'b1;
            tx_pending <= 1'b0;
            tx_hold <= 8'h00;
        end else if (init_any) begin
            tx_buffer_free <= 1'b1;
            tx_pending <= 1'b0;
        end else if (wr_tx_buf && tx_buffer_free) begin
            tx_hold <= reg_wdata[7:0];
            tx_pending <= 1'b1;
            tx_buffer_free <= 1'b0;
        end else if (tx_pending && tx_state == amsi_idle && !break_bit) begin
            tx_pending <= 1'b0;
            tx_buffer_free <= 1'b1;
        end
    end

    // Transmitter engine: start, data plus parity, one stop bit.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state <= amsi_idle;
            tx_cnt <= 12'h000;
            tx_bits <= 4'h0;
            tx_shift <= 9'h000;
        end else if (init_any) begin
            // Initialise abandons a frame so the line returns to mark.
            tx_state <= amsi_idle;
        end else begin
            case (tx_state)
                amsi_idle: begin
                    if (tx_pending && !break_bit && !init_any) begin
                        tx_shift <= {1'b0, tx_hold};
                        tx_shift[char_len] <= parity_on ?
                            (par_of({1'b0, tx_hold}, char_len) ^
                             !line_param[amsi_pos_par_type]) :
                            tx_hold[char_len[2:0]];
                        tx_cnt <= amsi_bit_cycles;
                        tx_bits <= 4'h0;
                        tx_state <= amsi_start;
                    end
                end
                amsi_start, amsi_data: begin
                    if (tx_cnt == 12'h000) begin
                        tx_cnt <= amsi_bit_cycles;
                        if (tx_state == amsi_data) begin
                            tx_bits <= tx_bits + 4'h1;
                        end
                        if (tx_state == amsi_data &&
                            tx_bits + 4'h1 == frame_bits) begin
                            tx_state <= amsi_stop;
                        end else begin
                            tx_state <= amsi_data;
                        end
                    end else begin
                        tx_cnt <= tx_cnt - 12'h001;
                    end
                end
                amsi_stop: begin
                    if (tx_cnt == 12'h000) begin
                        tx_state <= amsi_idle;
                    end else begin
                        tx_cnt <= tx_cnt - 12'h001;
                    end
                end
                default: begin
                    tx_state <= amsi_idle;
                end
            endcase
        end
    end

    // Line driver: break forces space, otherwise start, data or mark.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_tx <= 1'b1;
        end else if (break_bit) begin
            serial_tx <= 1'b0;
        end else begin
            case (tx_state)
                amsi_start: serial_tx <= 1'b0;
                amsi_data: serial_tx <= tx_shift[tx_bits];
                default: serial_tx <= 1'b1;
            endcase
        end
    end

    // Modem control outputs and level interrupt requests.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            modem_out <= '0;
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            modem_out.rev_tx <= reverse_channel_tx_bit;
            modem_out.rts <= rts_bit;
            modem_out.dtr <= dtr_bit;
            rx_irq <= (rx_char_available & rx_irq_enable) |
                (line_change_flag & line_change_irq_enable);
            tx_irq <= tx_buffer_free & tx_irq_enable;
        end
    end

    // Read data, valid in the cycle after the read strobe.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= amsi_zero_word;
        end else if (reg_rd) begin
            reg_rdata <= amsi_zero_word;
            case (reg_addr)
                amsi_rx_csr_addr: begin
                    reg_rdata[amsi_pos_line_change] <= line_change_flag;
                    reg_rdata[amsi_pos_ring] <= line_now[4];
                    reg_rdata[amsi_pos_cts] <= line_now[3];
                    reg_rdata[amsi_pos_carrier] <= line_now[2];
                    reg_rdata[amsi_pos_rev_rx] <= line_now[1];
                    reg_rdata[amsi_pos_dsr] <= line_now[0];
                    reg_rdata[amsi_pos_rx_avail] <= rx_char_available;
                    reg_rdata[amsi_pos_rx_ie] <= rx_irq_enable;
                    reg_rdata[amsi_pos_lc_ie] <= line_change_irq_enable;
                    reg_rdata[amsi_pos_rev_tx] <= reverse_channel_tx_bit;
                    reg_rdata[amsi_pos_rts] <= rts_bit;
                    reg_rdata[amsi_pos_dtr] <= dtr_bit;
                end
                amsi_rx_buf_addr: begin
                    reg_rdata[amsi_pos_err_any] <= overrun_flag |
                        framing_flag | parity_flag;
                    reg_rdata[amsi_pos_overrun] <= overrun_flag;
                    reg_rdata[amsi_pos_framing] <= framing_flag;
                    reg_rdata[amsi_pos_parity] <= parity_flag;
                    reg_rdata[7:0] <= rx_data;
                end
                amsi_tx_csr_addr: begin
                    reg_rdata[amsi_pos_tx_free] <= tx_buffer_free;
                    reg_rdata[amsi_pos_tx_ie] <= tx_irq_enable;
                    reg_rdata[amsi_pos_break] <= break_bit;
                end
                default: begin
                    reg_rdata <= amsi_zero_word;
                end
            endcase
        end else begin
            reg_rdata <= amsi_zero_word;
        end
    end

endmodule // amsi_modem_if

// >>> rtl/amsi_pkg.sv
package amsi_pkg;

    // Register indices on the plain register port.
    localparam logic [1:0] amsi_rx_csr_addr = 2'h0;
    localparam logic [1:0] amsi_rx_buf_addr = 2'h1;
    localparam logic [1:0] amsi_tx_csr_addr = 2'h2;
    localparam logic [1:0] amsi_tx_buf_addr = 2'h3;

    // Receiver control/status field positions.
    localparam int amsi_pos_line_change = 15;
    localparam int amsi_pos_ring = 14;
    localparam int amsi_pos_cts = 13;
    localparam int amsi_pos_carrier = 12;
    localparam int amsi_pos_rev_rx = 10;
    localparam int amsi_pos_dsr = 9;
    localparam int amsi_pos_rx_avail = 7;
    localparam int amsi_pos_rx_ie = 6;
    localparam int amsi_pos_lc_ie = 5;
    localparam int amsi_pos_rev_tx = 3;
    localparam int amsi_pos_rts = 2;
    localparam int amsi_pos_dtr = 1;

    // Receive buffer field positions.
    localparam int amsi_pos_err_any = 15;
    localparam int amsi_pos_overrun = 14;
    localparam int amsi_pos_framing = 13;
    localparam int amsi_pos_parity = 12;

    // Transmit control/status field positions.
    localparam int amsi_pos_tx_free = 7;
    localparam int amsi_pos_tx_ie = 6;
    localparam int amsi_pos_break = 0;

    // Parameter field positions and reset values.
    localparam int amsi_pos_par_type = 5;
    localparam int amsi_pos_par_on = 4;
    localparam int amsi_pos_len_hi = 3;
    localparam int amsi_pos_len_lo = 2;
    localparam logic [7:0] amsi_param_reset = 8'h0c;
    localparam logic [15:0] amsi_zero_word = 16'h0000;

    // Serial timing: bit time in reference clocks, sample at the middle.
    localparam int amsi_clk_hz = 10000000;
    localparam int amsi_baud = 9600;
    localparam logic [11:0] amsi_bit_cycles =
        12'(amsi_clk_hz / amsi_baud);
    localparam logic [11:0] amsi_half_cycles =
        12'(amsi_clk_hz / amsi_baud / 2);

    // Modem inputs, grouped.
    typedef struct packed {
        logic ring;
        logic cts;
        logic carrier;
        logic rev_rx;
        logic dsr;
    } amsi_modem_in_type;

    // Modem control outputs, grouped.
    typedef struct packed {
        logic rev_tx;
        logic rts;
        logic dtr;
    } amsi_modem_out_type;

    // Serial engine states.
    typedef enum logic [3:0] {
        amsi_idle = 4'b0001,
        amsi_start = 4'b0010,
        amsi_data = 4'b0100,
        amsi_stop = 4'b1000
    } amsi_state_type;

endpackage : amsi_pkg
